// [logic/tfrm_defines.vh]
/*
 * Constants for the frame and rate timing block: rate codes, channel counts,
 * frame lengths, timing figures and host port map.
 * Assumes a 40 MHz system clock and a high-speed tick enable standing for
 * the loop's 65.536 MHz timebase.
 */
`ifndef TFRM_DEFINES_VH
`define TFRM_DEFINES_VH

`define TFRM_CLK_MHZ 40
// Stream rate codes in the low three bits of each stream control field.
`define TFRM_RATE_2M 3'h0
`define TFRM_RATE_4M 3'h1
`define TFRM_RATE_8M 3'h2
`define TFRM_CH_2M 8'h20
`define TFRM_CH_4M 8'h40
`define TFRM_CH_8M 8'h80
`define TFRM_MAX_CHANNELS 10'h200
// Input clocking select codes.
`define TFRM_CKIN_16M 3'h0
`define TFRM_CKIN_8M 3'h1
`define TFRM_CKIN_4M 3'h2
// Last high-speed tick index of the 8 kHz frame.
`define TFRM_FRAME_LAST 13'h1fff
// Output clock half periods in high-speed ticks.
`define TFRM_HALF_32M 4'h1
`define TFRM_HALF_16M 4'h2
`define TFRM_HALF_8M 4'h4
`define TFRM_HALF_4M 4'h8
// Loop modes and reference rates.
`define TFRM_PLL_MASTER 2'h0
`define TFRM_PLL_FREE 2'h1
`define TFRM_PLL_BYPASS 2'h2
`define TFRM_REF_8K 2'h0
`define TFRM_REF_1544K 2'h1
`define TFRM_REF_2048K 2'h2
`define TFRM_REF_LAST_1544K 8'hc0
`define TFRM_REF_LAST_2048K 8'hff
// Boundary jitter tolerance.
`define TFRM_JITTER_NS 20
`define TFRM_JITTER_CYC ((`TFRM_JITTER_NS * `TFRM_CLK_MHZ + 999) / 1000)
// Host port: message memory occupies the low 512 addresses.
`define TFRM_MSG_WORDS 512
`define TFRM_MSG_EN_BIT 8

`endif

// [logic/tfrm_frame_timing.v]
/*
 * Frame and rate timing of a 16-in, 16-out serial switch: input boundary
 * finder, output clock and frame pulse pairs, loop timing source, message
 * memory and host port.
 * Assumes all inputs synchronous to i_clk and an external tick enable that
 * marks the loop's high-speed timebase.
 */
// Operation
// R1: each input stream picks one of three rates from its low three bits.
// R2: total input channels over all inputs must not exceed 512.
// R3: source supplies 8 kHz frame pulse low for width of highest rate.
// R4: source supplies input clock at twice the highest input rate.
// R5: input clocking field 000/001/010 selects 16/8/4 MHz clock; rest reserved.
// R6: polarity bits select input pulse and clock polarity, negative by default.
// R7: input boundary is a falling input clock edge while the pulse is low.
// R8: input frames carry 32, 64 or 128 channels per stream rate.
// R9: boundary finder active only with both bits high, off after reset.
// R10: each output stream picks one of three rates from its low bits.
// R11: three output frame pulses each repeat at the 8 kHz frame rate.
// R12: output boundary is a falling output clock edge while pulse low.
// R13: pair a gives 244 ns with 4 MHz, or 122 ns with 8 MHz.
// R14: pair b gives 61 ns with 16 MHz, or 122 ns with 8 MHz.
// R15: pair c gives 30 ns with 32 MHz, or 61 ns with 16 MHz.
// R16: each output pulse and clock has a polarity bit, negative by default.
// R17: output frames carry 32, 64 or 128 channels per stream rate.
// R18: loop runs master, free or bypass; bypass times from input signals.
// R19: master locks to reference or to the input-derived frame event.
// R20: channels in message mode send host-written bytes instead of switched data.
// R21: host port reads and writes with 12-bit address, 16-bit data.
// R22: reset disables output drivers, forces tristate controls high, clears state; the message memory is not cleared.
// R23: reserved input clocking codes keep the previous timing setting.
`include "tfrm_defines.vh"

module tfrm_frame_timing (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Input timing and stream rate control
    input wire i_in_serial_clock,
    input wire i_in_frame_pulse,
    input wire [2:0] i_in_clocking_select,
    input wire i_in_pulse_polarity,
    input wire i_in_clock_polarity,
    input wire i_boundary_det_enable,
    input wire i_boundary_det_select,
    input wire [47:0] i_in_stream_control,
    input wire [47:0] i_out_stream_control,
    // Output pair control
    input wire i_pair_a_rate_sel,
    input wire i_pair_b_rate_sel,
    input wire i_pair_c_rate_sel,
    input wire i_pulse_a_polarity,
    input wire i_pulse_b_polarity,
    input wire i_pulse_c_polarity,
    input wire i_clock_a_polarity,
    input wire i_clock_b_polarity,
    input wire i_clock_c_polarity,
    // Loop timing source
    input wire i_hs_tick,
    input wire [1:0] i_pll_mode,
    input wire i_lock_to_input,
    input wire [1:0] i_ref_rate_sel,
    input wire i_ref,
    // Message lookup by output slot
    input wire [8:0] i_msg_index,
    input wire [7:0] i_switched_data,
    input wire [15:0] i_tristate_req,
    // Host port
    input wire i_cs_n,
    input wire i_ds_n,
    input wire i_rd_wr,
    input wire [11:0] i_addr,
    input wire [15:0] i_data,
    output reg [15:0] o_data,
    output reg o_data_oe_n,
    output reg o_ack_n,
    // Input timing status and channel totals
    output reg o_in_boundary,
    output reg [10:0] o_in_edge_count,
    output reg [2:0] o_in_clocking_active,
    output reg [9:0] o_in_chan_total,
    output reg o_in_overload,
    output reg o_in_rate_error,
    output reg [9:0] o_out_chan_total,
    // Output pairs
    output reg o_out_clock_a,
    output reg o_out_clock_b,
    output reg o_out_clock_c,
    output reg o_out_pulse_a,
    output reg o_out_pulse_b,
    output reg o_out_pulse_c,
    output reg o_out_boundary,
    // Output data path
    output reg [7:0] o_slot_data,
    output reg o_slot_is_msg,
    output reg o_out_drive_en,
    output reg [15:0] o_tristate_control_outs
);

    function [7:0] tfrm_chans;
        input [2:0] code;
        begin
            case (code)
                `TFRM_RATE_2M: tfrm_chans = `TFRM_CH_2M;
                `TFRM_RATE_4M: tfrm_chans = `TFRM_CH_4M;
                `TFRM_RATE_8M: tfrm_chans = `TFRM_CH_8M;
                default: tfrm_chans = 8'h00;
            endcase
        end
    endfunction

    // Output clock is low in [0,half) so its falling edge sits on tick 0.
    function tfrm_clk;
        input [12:0] cnt;
        input [3:0] half;
        begin
            tfrm_clk = ((cnt / {9'h000, half}) % 13'h0002) == 13'h0001;
        end
    endfunction

    // Pulse is low for one clock period centred on the frame boundary.
    function tfrm_pulse_low;
        input [12:0] cnt;
        input [3:0] half;
        begin
            tfrm_pulse_low = (cnt < {9'h000, half}) ||
                (cnt > (`TFRM_FRAME_LAST - {9'h000, half}));
        end
    endfunction

    reg [2:0] ckin_sel;
    reg clk_q;
    reg [`TFRM_JITTER_CYC-1:0] fp_hist;
    reg [12:0] frame_cnt;
    reg [7:0] ref_cnt;
    reg ref_q;
    reg [1:0] host_q;
    reg [8:0] msg_mem [0:`TFRM_MSG_WORDS-1];
    reg [8:0] msg_word;
    wire clk_now;
    wire fp_low_now;
    wire clk_fall;
    wire det_on;
    wire in_bound;
    wire ref_rise;
    wire ref_event;
    wire sync_event;
    wire [3:0] half_a;
    wire [3:0] half_b;
    wire [3:0] half_c;
    wire access;
    wire access_start;
    reg [11:0] next_in_total;
    reg [11:0] next_out_total;
    reg next_rate_err;
    reg [2:0] max_code;
    reg [12:0] next_frame_cnt;
    integer i;

    // Inputs are folded to negative format before edge detection.
    assign clk_now = i_in_serial_clock ^ i_in_clock_polarity; // R6
    assign fp_low_now = ~(i_in_frame_pulse ^ i_in_pulse_polarity); // R6
    assign clk_fall = clk_q & ~clk_now;
    assign det_on = i_boundary_det_enable & i_boundary_det_select; // R9
    // With the finder on, a pulse seen low within the jitter window still
    // qualifies, so an edge that lands just after the pulse rises is kept.
    assign in_bound = clk_fall & (fp_low_now | (det_on & (|fp_hist))); // R7 R9

    assign ref_rise = i_ref & ~ref_q;
    assign ref_event = ref_rise &&
        ((i_ref_rate_sel == `TFRM_REF_8K) ||
         (i_ref_rate_sel == `TFRM_REF_1544K && ref_cnt == `TFRM_REF_LAST_1544K) ||
         (i_ref_rate_sel == `TFRM_REF_2048K && ref_cnt == `TFRM_REF_LAST_2048K));
    assign sync_event = (i_pll_mode == `TFRM_PLL_BYPASS) ? in_bound : // R18
        (i_pll_mode == `TFRM_PLL_MASTER) ?
        (i_lock_to_input ? in_bound : ref_event) : 1'b0; // R19

    assign half_a = i_pair_a_rate_sel ? `TFRM_HALF_8M : `TFRM_HALF_4M; // R13
    assign half_b = i_pair_b_rate_sel ? `TFRM_HALF_8M : `TFRM_HALF_16M; // R14
    assign half_c = i_pair_c_rate_sel ? `TFRM_HALF_16M : `TFRM_HALF_32M; // R15

    assign access = ~i_cs_n & ~i_ds_n;
    assign access_start = host_q == 2'h1;

    always @*
    begin
        next_in_total = 12'h000;
        next_out_total = 12'h000;
        next_rate_err = 1'b0;
        max_code = `TFRM_RATE_8M - ckin_sel;
        for (i = 0; i < 16; i = i + 1)
        begin
            next_in_total = next_in_total +
                {4'h0, tfrm_chans(i_in_stream_control[i*3 +: 3])}; // R1 R8
            next_out_total = next_out_total +
                {4'h0, tfrm_chans(i_out_stream_control[i*3 +: 3])}; // R10 R17
            if (tfrm_chans(i_in_stream_control[i*3 +: 3]) != 8'h00 &&
                i_in_stream_control[i*3 +: 3] > max_code)
            begin
                next_rate_err = 1'b1; // R4
            end
        end
    end

    always @*
    begin
        next_frame_cnt = frame_cnt;
        if (sync_event)
        begin
            next_frame_cnt = 13'h0000;
        end
        else if (i_hs_tick)
        begin
            next_frame_cnt = (frame_cnt == `TFRM_FRAME_LAST) ? 13'h0000 :
                frame_cnt + 13'h0001; // R11
        end
    end

    // Input boundary, counters and configuration.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ckin_sel <= `TFRM_CKIN_16M;
            clk_q <= 1'b0;
            fp_hist <= {`TFRM_JITTER_CYC{1'b0}};
            ref_q <= 1'b0;
            ref_cnt <= 8'h00;
            frame_cnt <= 13'h0000; // R22
            o_in_boundary <= 1'b0;
            o_in_edge_count <= 11'h000;
            o_in_clocking_active <= `TFRM_CKIN_16M;
            o_in_chan_total <= 10'h000;
            o_in_overload <= 1'b0;
            o_in_rate_error <= 1'b0;
            o_out_chan_total <= 10'h000;
        end
        else
        begin
            if (i_in_clocking_select <= `TFRM_CKIN_4M)
            begin
                ckin_sel <= i_in_clocking_select; // R5 R23
            end
            o_in_clocking_active <= ckin_sel;
            clk_q <= clk_now;
            fp_hist <= (fp_hist << 1) | fp_low_now; // R9
            ref_q <= i_ref;
            if (ref_rise)
            begin
                ref_cnt <= ref_event ? 8'h00 : ref_cnt + 8'h01;
            end
            frame_cnt <= next_frame_cnt;
            o_in_boundary <= in_bound; // R7
            if (in_bound)
            begin
                o_in_edge_count <= 11'h000;
            end
            else if (clk_fall)
            begin
                o_in_edge_count <= o_in_edge_count + 11'h001;
            end
            o_in_chan_total <= next_in_total[9:0];
            o_in_overload <= next_in_total > `TFRM_MAX_CHANNELS; // R2
            o_in_rate_error <= next_rate_err;
            o_out_chan_total <= next_out_total[9:0];
        end
    end

    // Output pairs; the polarity bits invert the negative-format signal.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_out_clock_a <= 1'b1;
            o_out_clock_b <= 1'b1;
            o_out_clock_c <= 1'b1;
            o_out_pulse_a <= 1'b1;
            o_out_pulse_b <= 1'b1;
            o_out_pulse_c <= 1'b1;
            o_out_boundary <= 1'b0;
        end
        else
        begin
            o_out_clock_a <= tfrm_clk(next_frame_cnt, half_a) ^ i_clock_a_polarity; // R16
            o_out_clock_b <= tfrm_clk(next_frame_cnt, half_b) ^ i_clock_b_polarity; // R16
            o_out_clock_c <= tfrm_clk(next_frame_cnt, half_c) ^ i_clock_c_polarity; // R16
            o_out_pulse_a <= ~tfrm_pulse_low(next_frame_cnt, half_a) ^
                i_pulse_a_polarity; // R12 R13 R16
            o_out_pulse_b <= ~tfrm_pulse_low(next_frame_cnt, half_b) ^
                i_pulse_b_polarity; // R12 R14 R16
            o_out_pulse_c <= ~tfrm_pulse_low(next_frame_cnt, half_c) ^
                i_pulse_c_polarity; // R12 R15 R16
            o_out_boundary <= (next_frame_cnt == 13'h0000) &&
                (frame_cnt != 13'h0000); // R12
        end
    end

    // Message memory has no reset; the enable bit is cleared by software
    // before use, so stale bytes cannot reach a slot unasked.
    always @(posedge i_clk)
    begin
        if (i_rst_n && access_start && !i_rd_wr && i_addr < `TFRM_MSG_WORDS)
        begin
            msg_mem[i_addr[8:0]] <= i_data[8:0]; // R20 R21
        end
        msg_word <= msg_mem[i_msg_index];
    end

    // Host port and output data path.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            host_q <= 2'h0;
            o_data <= 16'h0000;
            o_data_oe_n <= 1'b1;
            o_ack_n <= 1'b1;
            o_slot_data <= 8'h00;
            o_slot_is_msg <= 1'b0;
            o_out_drive_en <= 1'b0; // R22
            o_tristate_control_outs <= 16'hffff; // R22
        end
        else
        begin
            host_q <= {host_q[0], access};
            o_ack_n <= ~(access & host_q[0]); // R21
            o_data_oe_n <= ~(access & host_q[0] & i_rd_wr); // R21
            if (access_start && i_rd_wr)
            begin
                o_data <= (i_addr < `TFRM_MSG_WORDS) ?
                    {7'h00, msg_mem[i_addr[8:0]]} : 16'h0000; // R21
            end
            o_slot_is_msg <= msg_word[`TFRM_MSG_EN_BIT];
            o_slot_data <= msg_word[`TFRM_MSG_EN_BIT] ? msg_word[7:0] :
                i_switched_data; // R20
            o_out_drive_en <= 1'b1;
            o_tristate_control_outs <= i_tristate_req;
        end
    end

endmodule // tfrm_frame_timing

// [verification/tb.sv]
/*
 * Self-checking bench of the frame timing block.
 * Assumes the source model drives the input clock and pulse, and the bench a tick on every cycle.
 */
`include "tfrm_defines.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    int err_total = 0, n_tests = 0;
    logic i_clk = 0, i_rst_n = 0, i_cs_n = 1, i_ds_n = 1, i_rd_wr = 1, i_hs_tick = 1;
    logic i_in_pulse_polarity = 0, i_in_clock_polarity = 0, i_lock_to_input = 0;
    logic i_boundary_det_enable = 0, i_boundary_det_select = 0;
    logic i_pair_a_rate_sel = 0, i_pair_b_rate_sel = 0, i_pair_c_rate_sel = 0;
    logic i_pulse_a_polarity = 0, i_pulse_b_polarity = 0, i_pulse_c_polarity = 0;
    logic i_clock_a_polarity = 0, i_clock_b_polarity = 0, i_clock_c_polarity = 0;
    logic [2:0] i_in_clocking_select = 0;
    logic [47:0] i_in_stream_control = 0, i_out_stream_control = 0;
    logic [1:0] i_pll_mode = 2'h1, i_ref_rate_sel = 0;
    logic [8:0] i_msg_index = 0;
    logic [7:0] i_switched_data = 8'h3c;
    logic [15:0] i_tristate_req = 0, i_data = 0, o_data, o_tristate_control_outs;
    logic [11:0] i_addr = 0;
    logic [10:0] edges = 11'h020, o_in_edge_count;
    logic [9:0] o_in_chan_total, o_out_chan_total;
    logic [7:0] o_slot_data;
    logic [2:0] o_in_clocking_active, cq = 3'h7;
    logic i_in_serial_clock, i_in_frame_pulse, o_data_oe_n, o_ack_n, o_in_boundary, o_in_overload;
    logic o_in_rate_error, o_out_clock_a, o_out_clock_b, o_out_clock_c, o_out_pulse_a;
    logic o_out_pulse_b, o_out_pulse_c, o_out_boundary, o_slot_is_msg, o_out_drive_en;
    // The reference is the source's frame pulse, so a reference lock keeps its frame.
    wire i_ref = i_in_frame_pulse;
    logic [5:0] pb;
    int lw[3], fl[3], lws[3], fls[3];
    int hh[2][3] = '{'{8, 2, 1}, '{4, 4, 2}};
    wire [2:0] pv = {o_out_pulse_c, o_out_pulse_b, o_out_pulse_a};
    wire [2:0] cv = {o_out_clock_c, o_out_clock_b, o_out_clock_a};
    tfrm_frame_timing tfrm_frame_timing_i (.*);
    tfrm_in_source tfrm_in_source_i (.i_clk(i_clk), .i_ck_pol(i_in_clock_polarity),
        .i_fp_pol(i_in_pulse_polarity), .i_edges(edges), .o_ck(i_in_serial_clock),
        .o_fp(i_in_frame_pulse));
    always #12.5 i_clk = ~i_clk;
    // Low cycles of each pulse and falls of each clock, totalled per output frame.
    always @(posedge i_clk)
    begin
        for (int k = 0; k < 3; k++)
        begin
            lw[k] += int'(!pv[k]);
            fl[k] += int'(cq[k] && !cv[k]);
            if (o_out_boundary)
            begin
                lws[k] = lw[k];
                fls[k] = fl[k];
                lw[k] = 0;
                fl[k] = 0;
            end
        end
        if (o_out_boundary)
            pb = {pv, cv};
        cq = cv;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    task automatic rst();
        i_rst_n = 1'b0;
        cyc(16);
        `CHK({o_out_drive_en, o_tristate_control_outs}, 17'h0_ffff)
        i_rst_n = 1'b1;
    endtask
    task automatic acc(input logic rw, input logic [11:0] a, input logic [15:0] d,
        output logic [15:0] q);
        int n;
        i_rd_wr = rw;
        i_addr = a;
        i_data = d;
        i_cs_n = 1'b0;
        i_ds_n = 1'b0;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end while (o_ack_n !== 1'b0 && n < 20);
        q = o_data;
        `CHK(n < 20, 1'b1)
        #2 i_cs_n = 1'b1;
        i_ds_n = 1'b1;
        cyc(1);
    endtask
    task automatic waitfor(input int k, output int n);
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end while ((k ? o_out_boundary : o_in_boundary) !== 1'b1 && n < 20000);
        if (n >= 20000)
            err_total++;
        #2;
    endtask
    task automatic gap(input int k, input int exp);
        int n;
        repeat (3) waitfor(k, n);
        `CHK(n, exp)
        if (k == 0)
            `CHK(o_in_edge_count, 11'h000)
    endtask
    function automatic int ch(input logic [2:0] c);
        return c == `TFRM_RATE_2M ? 32 : c == `TFRM_RATE_4M ? 64 : c == `TFRM_RATE_8M ? 128 : 0;
    endfunction
    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        logic [15:0] q;
        int n, e;
        rst();
        acc(1'b0, 12'h005, 16'h01a5, q);
        acc(1'b0, 12'h006, 16'h0042, q);
        acc(1'b0, 12'h300, 16'hffff, q);
        acc(1'b1, 12'h005, 16'h0000, q);
        `CHK(q, 16'h01a5)
        acc(1'b1, 12'h300, 16'h0000, q);
        `CHK(q, 16'h0000)
        i_msg_index = 9'h005;
        cyc(2);
        `CHK({o_slot_is_msg, o_slot_data}, 9'h1a5)
        i_msg_index = 9'h006;
        cyc(2);
        `CHK({o_slot_is_msg, o_slot_data}, 9'h03c)
        $display("test host done");
        e = 0;
        for (int k = 0; k < 16; k++)
        begin
            i_out_stream_control[3*k +: 3] = 3'(k % 4 == 3 ? 7 : k % 4);
            e += ch(i_out_stream_control[3*k +: 3]);
        end
        i_in_stream_control = 48'h0000_0000_0001;
        cyc(3);
        `CHK(o_out_chan_total, 10'(e))
        `CHK({o_in_overload, o_in_chan_total}, 11'h620)
        for (int c = 0; c < 3; c++)
        begin
            i_in_clocking_select = 3'(c);
            cyc(3);
            `CHK({o_in_clocking_active, o_in_rate_error}, {3'(c), c == 2})
        end
        i_in_clocking_select = 3'h5;
        i_in_stream_control = 48'h0000_0000_0000;
        cyc(3);
        `CHK({o_in_overload, o_in_clocking_active, o_in_chan_total}, 14'h0a00)
        $display("test rates done");
        gap(0, 4 * 32);
        i_in_clock_polarity = 1'b1;
        i_in_pulse_polarity = 1'b1;
        gap(0, 4 * 32);
        i_boundary_det_enable = 1'b1;
        i_boundary_det_select = 1'b1;
        gap(0, 4 * 32);
        $display("test input timing done");
        for (int s = 0; s < 2; s++)
        begin
            {i_pair_a_rate_sel, i_pair_b_rate_sel, i_pair_c_rate_sel} = {3{s[0]}};
            rst();
            waitfor(1, n);
            waitfor(1, n);
            `CHK(n, 8192)
            `CHK(pb, 6'h00)
            for (int k = 0; k < 3; k++)
            begin
                `CHK(lws[k], 2 * hh[s][k])
                `CHK(fls[k], 4096 / hh[s][k])
            end
        end
        {i_pulse_a_polarity, i_pulse_b_polarity, i_pulse_c_polarity,
            i_clock_a_polarity, i_clock_b_polarity, i_clock_c_polarity} = 6'h3f;
        // Polarity is set ahead of a reset but cleared after the next boundary with no reset.
        rst();
        waitfor(1, n);
        `CHK(pb, 6'h3f)
        {i_pulse_a_polarity, i_pulse_b_polarity, i_pulse_c_polarity,
            i_clock_a_polarity, i_clock_b_polarity, i_clock_c_polarity} = 6'h00;
        $display("test output pairs done");
        edges = 11'h3e8;
        for (int m = 0; m < 3; m++)
        begin
            i_pll_mode = m ? 2'h0 : 2'h2;
            i_lock_to_input = m < 2;
            rst();
            gap(1, 4000);
        end
        $display("test timing source done");
        summarize();
    end
    initial
    begin
        repeat (90000) @(posedge i_clk);
        err_total++;
        summarize();
    end
endmodule // tb
bind tfrm_frame_timing tfrm_frame_timing_assertions tfrm_frame_timing_assertions_i (.*);

// [verification/tfrm_frame_timing_assertions.sv]
/*
 * Port checker of the frame timing block: host handshake, reset state,
 * input boundary and output pair shapes.
 * Assumes binding to the top module and i_hs_tick high on every cycle.
 */
module tfrm_frame_timing_assertions (
    // Clock, reset and host strobes
    input wire i_clk, input wire i_rst_n, input wire i_cs_n, input wire i_ds_n,
    // Input timing and pair control
    input wire i_in_frame_pulse, input wire i_in_pulse_polarity, input wire [1:0] i_pll_mode,
    input wire i_pair_a_rate_sel, input wire i_pair_c_rate_sel, input wire i_pulse_a_polarity,
    input wire i_clock_a_polarity, input wire i_pulse_c_polarity, input wire i_clock_c_polarity,
    // Watched outputs
    input wire o_ack_n, input wire o_data_oe_n, input wire o_in_boundary,
    input wire [10:0] o_in_edge_count, input wire o_out_boundary, input wire o_out_pulse_a,
    input wire o_out_clock_a, input wire o_out_pulse_c, input wire o_out_clock_c,
    input wire o_out_drive_en, input wire [15:0] o_tristate_control_outs
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire stb = !i_cs_n && !i_ds_n;
    wire fpa = i_in_frame_pulse ^ i_in_pulse_polarity;
    // Shapes are judged only after one whole free-running frame, since the
    // first frame after reset starts mid-pulse.
    logic seen;
    logic [12:0] gap_cnt;
    always @(posedge i_clk)
    begin
        seen <= i_rst_n && i_pll_mode == 2'h1 && (seen || o_out_boundary);
        gap_cnt <= (!i_rst_n || o_out_boundary) ? 13'h0000 : gap_cnt + 13'h0001;
    end
    chk_reset_state: assert property ($rose(i_rst_n) |->
        o_tristate_control_outs == 16'hffff && !o_out_drive_en) else $error("reset state wrong");
    chk_drive_on: assert property ($rose(i_rst_n) |=> o_out_drive_en)
        else $error("drivers not enabled");
    chk_ack_delay: assert property ($rose(stb) |-> ##[2:3] !o_ack_n)
        else $error("ack late");
    chk_ack_release: assert property (!stb ##1 !stb |=> o_ack_n && o_data_oe_n)
        else $error("ack not released");
    chk_oe_with_ack: assert property (!o_data_oe_n |-> !o_ack_n)
        else $error("data driven without ack");
    chk_in_boundary: assert property (o_in_boundary |->
        o_in_edge_count == 11'h000 && (!$past(fpa) || !$past(fpa, 2))) else $error("bad boundary");
    chk_out_edge_a: assert property (o_out_boundary && !i_pulse_a_polarity &&
        !i_clock_a_polarity |-> !o_out_pulse_a && !o_out_clock_a) else $error("pair a edge");
    chk_frame_len: assert property (o_out_boundary && seen |-> gap_cnt == 13'h1fff)
        else $error("frame length wrong");
    chk_pulse_a: assert property ($fell(o_out_pulse_a) && seen && !i_pair_a_rate_sel &&
        !i_pulse_a_polarity |-> (!o_out_pulse_a)[*8] ##1 (!o_out_pulse_a)[*8] ##1 o_out_pulse_a)
        else $error("pulse a width");
    chk_pulse_c: assert property ($fell(o_out_pulse_c) && seen && !i_pair_c_rate_sel &&
        !i_pulse_c_polarity |-> (!o_out_pulse_c)[*2] ##1 o_out_pulse_c) else $error("pulse c");
    chk_clock_c: assert property ($fell(o_out_clock_c) && seen && i_pair_c_rate_sel &&
        !i_clock_c_polarity |-> (!o_out_clock_c)[*2] ##1 o_out_clock_c[*2]) else $error("clock c");
    cov_in: cover property (o_in_boundary);
    cov_read: cover property ($fell(o_data_oe_n));
    cov_frame: cover property (o_out_boundary && seen);
endmodule // tfrm_frame_timing_assertions

// [verification/tfrm_in_source.sv]
/*
 * Model of the far-side source of the input serial clock and frame pulse.
 * Assumes a free-running clock of four system cycles per period.
 */
module tfrm_in_source (
    // System clock
    input wire logic i_clk,
    // Format and frame length in clock periods
    input wire logic i_ck_pol,
    input wire logic i_fp_pol,
    input wire logic [10:0] i_edges,
    // Lines
    output logic o_ck,
    output logic o_fp
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph = 2'h0;
    logic [10:0] ed = 11'h000;
    always @(posedge i_clk)
    begin
        ph <= ph + 2'h1;
        if (ph == 2'h3)
            ed <= (ed + 11'h001 >= i_edges) ? 11'h000 : ed + 11'h001;
    end
    // The pulse covers a whole clock period so it brackets the falling edge.
    assign #2 o_fp = (ed != 11'h000) ^ i_fp_pol;
    assign #2 o_ck = !ph[1] ^ i_ck_pol;
endmodule // tfrm_in_source
